//--- logic/hoc_override_regs.sv
// Host override control registers: switch and charger control, override control.
// Assumes byte accesses arrive from an I2C slave on sys_clk as one-cycle
// strobes, and that fault and engine signals are on sys_clk too.
//
// Notes on behaviour
// - Clear-fault write clears charger flag under override
// - Probe trigger switches charger monitor on/off
// - Probe pulses recovery once, updates flag, self-clears
// - Shutdown bit drives shutdown output directly
// - Automatic shutdown sets shutdown bit too
// - Precharge bit drives precharge switch output
// - Overcurrent faults clear precharge unless host override
// - Charge bit drives charge switch output
// - Charge overcurrent or short clears charge bit
// - Discharge bit drives discharge switch output
// - Discharge overcurrent or short clears discharge bit
// - Short circuit forces switches off despite override
// - Switch override hands switch control to host
// - Hard faults always force switches off
// - Balance override disables automatic balancing
// - Load override disables automatic load watch
// - Charger override disables automatic charger watch
// - Scan override stops automatic measurement scans
// - Watchdog clears scan override; resume on transaction
// - Open-wire trigger starts scan, clears on done
// - Open-wire trigger needs auto-disable or scan override
// - Balance-on gates selected balance outputs under override
module hoc_override_regs
#(
  parameter int PROBE_SETTLE_CYC = hoc_pkg::HOC_PROBE_SETTLE_CYC,
  parameter int CELLS = 8
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWrData,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic i2cTransaction,
  input wire logic watchdogExpired,
  input wire logic chargeOvercurrent,
  input wire logic dischargeOvercurrent,
  input wire logic dischargeShortCircuit,
  input wire logic openWireFault,
  input wire logic internalOvertemp,
  input wire logic cellOvervoltageLockout,
  input wire logic cellUndervoltageLockout,
  input wire logic sleepActive,
  input wire logic switchesOffInput,
  input wire logic cellFailEvent,
  input wire logic openWireEvent,
  input wire logic cellFailShutdownEnable,
  input wire logic openWireShutdownEnable,
  input wire logic ovloShutdownEnable,
  input wire logic openWireAutoDisable,
  input wire logic openWireScanDone,
  input wire logic [CELLS-1:0] balanceSwitchSelect,
  input wire logic chargerSensePin,
  input wire logic autoChargerPresent,
  output logic chargerPresentFlag,
  output logic chargerMonitorOn,
  output logic chargerRecoveryPulse,
  output logic packShutdownOutput,
  output logic prechargeSwitch,
  output logic chargeSwitch,
  output logic dischargeSwitch,
  output logic openWireScanStart,
  output logic [CELLS-1:0] hostBalanceDrive,
  output logic autoBalanceEnable,
  output logic autoLoadWatchEnable,
  output logic autoChargerWatchEnable,
  output logic autoScanEnable
);
  import hoc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic shutdownBit;
  logic prechargeBit;
  logic chargeBit;
  logic dischargeBit;
  logic probeBit;
  logic switchOverride;
  logic balanceOverride;
  logic loadOverride;
  logic chargerOverride;
  logic scanOverride;
  logic openWireBusy;
  logic balanceOn;
  logic scanHold;
  logic hostChargerFlag;
  logic senseMeta;
  logic senseSync;
  logic offMeta;
  logic offSync;

  // Probe sequencer results
  logic probeMonitorOn;
  logic probePulse;
  logic probeValid;
  logic probeResult;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and write strobes
  wire selSwitch = (regAddr == HOC_SWITCH_CTRL_ADDR);
  wire selOverride = (regAddr == HOC_OVERRIDE_CTRL_ADDR);
  wire wrSwitch = regWrite && selSwitch;
  wire wrOverride = regWrite && selOverride;

  // Writes that land this cycle, each field taken from the written byte
  wire wrShutdown = wrSwitch;
  wire wrProbeOne = wrSwitch && regWrData[HOC_PROBE_BIT] && chargerOverride;
  wire wrProbeZero = wrSwitch && !regWrData[HOC_PROBE_BIT];
  wire wrClearFault = wrSwitch && regWrData[HOC_CLEAR_FAULT_BIT] && chargerOverride;
  wire wrOwStart = wrOverride && regWrData[HOC_OW_START_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Fault terms
  // Overcurrent clears honour the host switch override, short circuit does not
  wire softGate = !switchOverride;
  wire clearPrecharge = softGate && (chargeOvercurrent || dischargeOvercurrent);
  wire clearCharge = softGate && chargeOvercurrent;
  wire clearDischarge = softGate && dischargeOvercurrent;
  // Hard faults override everything, including a host write in the same cycle
  wire hardOff = dischargeShortCircuit || openWireFault || internalOvertemp
    || cellOvervoltageLockout || cellUndervoltageLockout || sleepActive || offSync;

  // Automatic shutdown request from the enabled protection options
  wire autoShutdown = (cellFailShutdownEnable && cellFailEvent)
    || (openWireShutdownEnable && openWireEvent)
    || (ovloShutdownEnable && cellOvervoltageLockout);

  // Open-wire trigger only acts when auto open-wire is disabled or scans are host-run
  wire owAllowed = openWireAutoDisable || scanOverride;
  wire owAccept = wrOwStart && owAllowed && !openWireBusy;

  ////////////////////////////////////////////////////////////////////////////
  // Read-back images; reserved and out-of-block bits read as zero
  wire [7:0] switchImage = {
    2'b00,
    1'b0,
    probeBit,
    shutdownBit,
    prechargeBit,
    chargeBit,
    dischargeBit
  };
  wire [7:0] overrideImage = {
    1'b0,
    switchOverride,
    balanceOverride,
    loadOverride,
    chargerOverride,
    scanOverride,
    openWireBusy,
    balanceOn
  };
  wire [7:0] readSel = selSwitch ? switchImage :
    selOverride ? overrideImage : HOC_UNMAPPED_READ;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for the charger sense and switches-off inputs
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      senseMeta <= 1'b0;
      senseSync <= 1'b0;
      offMeta <= 1'b0;
      offSync <= 1'b0;
    end
    else if (clkEn)
    begin
      senseMeta <= chargerSensePin;
      senseSync <= senseMeta;
      offMeta <= switchesOffInput;
      offSync <= offMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power switch bits: write sets value, faults clear, clear wins over write
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      prechargeBit <= HOC_SWITCH_CTRL_RESET[HOC_PRECHARGE_BIT];
      chargeBit <= HOC_SWITCH_CTRL_RESET[HOC_CHARGE_BIT];
      dischargeBit <= HOC_SWITCH_CTRL_RESET[HOC_DISCHARGE_BIT];
    end
    else if (clkEn)
    begin
      if (hardOff || clearPrecharge)
        prechargeBit <= 1'b0;
      else if (wrSwitch)
        prechargeBit <= regWrData[HOC_PRECHARGE_BIT];
      if (hardOff || clearCharge)
        chargeBit <= 1'b0;
      else if (wrSwitch)
        chargeBit <= regWrData[HOC_CHARGE_BIT];
      if (hardOff || clearDischarge)
        dischargeBit <= 1'b0;
      else if (wrSwitch)
        dischargeBit <= regWrData[HOC_DISCHARGE_BIT];
    end
  end

  // Pack shutdown bit: automatic assertion wins over a host write of zero
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      shutdownBit <= HOC_SWITCH_CTRL_RESET[HOC_SHUTDOWN_BIT];
    else if (clkEn)
    begin
      if (autoShutdown)
        shutdownBit <= 1'b1;
      else if (wrShutdown)
        shutdownBit <= regWrData[HOC_SHUTDOWN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Charger probe trigger: held while the sequence runs, then self-clears
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      probeBit <= HOC_SWITCH_CTRL_RESET[HOC_PROBE_BIT];
    else if (clkEn)
    begin
      if (wrProbeOne)
        probeBit <= 1'b1;
      else if (wrProbeZero || probeValid || !chargerOverride)
        probeBit <= 1'b0;
    end
  end

  // Host-side charger flag: probe result loads, clear-fault write clears, probe result wins
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      hostChargerFlag <= 1'b0;
    else if (clkEn)
    begin
      if (probeValid)
        hostChargerFlag <= probeResult;
      else if (wrClearFault)
        hostChargerFlag <= 1'b0;
    end
  end

  // Probe sequencer, aborted by a write of zero or loss of the override
  hoc_probe_seq #(
    .SETTLE_CYC(PROBE_SETTLE_CYC)
  ) u_probe (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .start(wrProbeOne),
    .abort(wrProbeZero || !chargerOverride),
    .senseLevel(senseSync),
    .monitorOn(probeMonitorOn),
    .recoveryPulse(probePulse),
    .resultValid(probeValid),
    .result(probeResult)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Override control register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      switchOverride <= HOC_OVERRIDE_CTRL_RESET[HOC_SWITCH_OVR_BIT];
      balanceOverride <= HOC_OVERRIDE_CTRL_RESET[HOC_BAL_OVR_BIT];
      loadOverride <= HOC_OVERRIDE_CTRL_RESET[HOC_LOAD_OVR_BIT];
      chargerOverride <= HOC_OVERRIDE_CTRL_RESET[HOC_CHG_OVR_BIT];
      balanceOn <= HOC_OVERRIDE_CTRL_RESET[HOC_BAL_ON_BIT];
    end
    else if (clkEn && wrOverride)
    begin
      switchOverride <= regWrData[HOC_SWITCH_OVR_BIT];
      balanceOverride <= regWrData[HOC_BAL_OVR_BIT];
      loadOverride <= regWrData[HOC_LOAD_OVR_BIT];
      chargerOverride <= regWrData[HOC_CHG_OVR_BIT];
      balanceOn <= regWrData[HOC_BAL_ON_BIT];
    end
  end

  // Scan override: watchdog expiry clears it and wins over a write
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      scanOverride <= HOC_OVERRIDE_CTRL_RESET[HOC_SCAN_OVR_BIT];
    else if (clkEn)
    begin
      if (watchdogExpired)
        scanOverride <= 1'b0;
      else if (wrOverride)
        scanOverride <= regWrData[HOC_SCAN_OVR_BIT];
    end
  end

  // Hold automatic scans after expiry until the next bus transaction
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      scanHold <= 1'b0;
    else if (clkEn)
    begin
      if (watchdogExpired)
        scanHold <= 1'b1;
      else if (i2cTransaction)
        scanHold <= 1'b0;
    end
  end

  // Open-wire scan busy bit: set by an accepted trigger, cleared on completion
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      openWireBusy <= HOC_OVERRIDE_CTRL_RESET[HOC_OW_START_BIT];
    else if (clkEn)
    begin
      if (owAccept)
        openWireBusy <= 1'b1;
      else if (openWireScanDone)
        openWireBusy <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs and read data
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      regRdData <= HOC_UNMAPPED_READ;
      openWireScanStart <= 1'b0;
      hostBalanceDrive <= '0;
      chargerPresentFlag <= 1'b0;
    end
    else if (clkEn)
    begin
      if (regRead)
        regRdData <= readSel;
      openWireScanStart <= owAccept;
      hostBalanceDrive <= (balanceOverride && balanceOn) ? balanceSwitchSelect : '0;
      chargerPresentFlag <= chargerOverride ? hostChargerFlag : autoChargerPresent;
    end
  end

  // Pin drives follow their bits; the register already carries the forced clears
  assign packShutdownOutput = shutdownBit;
  assign prechargeSwitch = prechargeBit;
  assign chargeSwitch = chargeBit;
  assign dischargeSwitch = dischargeBit;
  assign chargerMonitorOn = probeMonitorOn;
  assign chargerRecoveryPulse = probePulse;

  // Automatic engine enables
  assign autoBalanceEnable = !balanceOverride;
  assign autoLoadWatchEnable = !loadOverride;
  assign autoChargerWatchEnable = !chargerOverride;
  assign autoScanEnable = !scanOverride && !scanHold;

endmodule // hoc_override_regs

//--- shared/hoc_pkg.sv
// Constants for the host override control register bank.
// Assumes a 250 MHz system clock and 8-bit register access from an I2C slave.
package hoc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] HOC_SWITCH_CTRL_ADDR = 8'h86;
  localparam logic [7:0] HOC_OVERRIDE_CTRL_ADDR = 8'h87;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions in the switch and charger control register
  localparam int HOC_DISCHARGE_BIT = 0;
  localparam int HOC_CHARGE_BIT = 1;
  localparam int HOC_PRECHARGE_BIT = 2;
  localparam int HOC_SHUTDOWN_BIT = 3;
  localparam int HOC_PROBE_BIT = 4;
  localparam int HOC_CLEAR_FAULT_BIT = 5;

  // Field positions in the override control register
  localparam int HOC_BAL_ON_BIT = 0;
  localparam int HOC_OW_START_BIT = 1;
  localparam int HOC_SCAN_OVR_BIT = 2;
  localparam int HOC_CHG_OVR_BIT = 3;
  localparam int HOC_LOAD_OVR_BIT = 4;
  localparam int HOC_BAL_OVR_BIT = 5;
  localparam int HOC_SWITCH_OVR_BIT = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and read answers
  localparam logic [7:0] HOC_SWITCH_CTRL_RESET = 8'h00;
  localparam logic [7:0] HOC_OVERRIDE_CTRL_RESET = 8'h00;
  localparam logic [7:0] HOC_UNMAPPED_READ = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int HOC_CLK_MHZ = 250;
  localparam int HOC_PROBE_SETTLE_NS = 1000;
  // Least time, so round up to whole cycles
  localparam int HOC_PROBE_SETTLE_CYC = (HOC_PROBE_SETTLE_NS * HOC_CLK_MHZ + 999) / 1000;
  localparam int HOC_SETTLE_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Charger probe sequencer states
  typedef enum logic [1:0] {
    HOC_PROBE_IDLE = 2'b00,
    HOC_PROBE_PULSE = 2'b01,
    HOC_PROBE_SETTLE = 2'b10,
    HOC_PROBE_SAMPLE = 2'b11
  } hoc_probe_state_e;

endpackage : hoc_pkg

//--- logic/hoc_probe_seq.sv
// Charger probe sequencer: monitor on, one recovery pulse, settle, sample.
// Assumes the sense input is already synchronised to sys_clk.
module hoc_probe_seq
#(
  parameter int SETTLE_CYC = hoc_pkg::HOC_PROBE_SETTLE_CYC
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic start,
  input wire logic abort,
  input wire logic senseLevel,
  output logic monitorOn,
  output logic recoveryPulse,
  output logic resultValid,
  output logic result
);
  import hoc_pkg::*;

  hoc_probe_state_e state;
  hoc_probe_state_e next_state;
  logic [HOC_SETTLE_W-1:0] settleCount;
  wire settleDone = (settleCount == HOC_SETTLE_W'(SETTLE_CYC - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Next-state selection
  always_comb
  begin
    next_state = state;
    unique case (state)
      HOC_PROBE_IDLE: if (start) next_state = HOC_PROBE_PULSE;
      HOC_PROBE_PULSE: next_state = HOC_PROBE_SETTLE;
      HOC_PROBE_SETTLE: if (settleDone) next_state = HOC_PROBE_SAMPLE;
      HOC_PROBE_SAMPLE: next_state = HOC_PROBE_IDLE;
    endcase
    if (abort) next_state = HOC_PROBE_IDLE;
  end

  // State and settle counter
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state <= HOC_PROBE_IDLE;
      settleCount <= '0;
    end
    else if (clkEn)
    begin
      state <= next_state;
      settleCount <= (state == HOC_PROBE_SETTLE) ? settleCount + 1'b1 : '0;
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      monitorOn <= 1'b0;
      recoveryPulse <= 1'b0;
      resultValid <= 1'b0;
      result <= 1'b0;
    end
    else if (clkEn)
    begin
      monitorOn <= (next_state != HOC_PROBE_IDLE);
      recoveryPulse <= (next_state == HOC_PROBE_PULSE);
      resultValid <= (state == HOC_PROBE_SAMPLE) && !abort;
      if (state == HOC_PROBE_SAMPLE)
        result <= senseLevel;
    end
  end

endmodule // hoc_probe_seq

//--- test/hoc_override_regs_checker.sv
// Concurrent checks on the host override register bank ports.
// Assumes one sys_clk domain and the synchronous sys_rst of the top module.
module hoc_regs_checker
#(
  parameter int CELLS = 8
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWrData,
  input wire logic i2cTransaction,
  input wire logic watchdogExpired,
  input wire logic dischargeShortCircuit,
  input wire logic internalOvertemp,
  input wire logic sleepActive,
  input wire logic cellOvervoltageLockout,
  input wire logic ovloShutdownEnable,
  input wire logic openWireAutoDisable,
  input wire logic openWireScanDone,
  input wire logic [CELLS-1:0] balanceSwitchSelect,
  input wire logic chargerMonitorOn,
  input wire logic chargerRecoveryPulse,
  input wire logic packShutdownOutput,
  input wire logic prechargeSwitch,
  input wire logic chargeSwitch,
  input wire logic dischargeSwitch,
  input wire logic openWireScanStart,
  input wire logic [CELLS-1:0] hostBalanceDrive,
  input wire logic autoBalanceEnable,
  input wire logic autoLoadWatchEnable,
  input wire logic autoChargerWatchEnable,
  input wire logic autoScanEnable
);
  timeunit 1ns;
  timeprecision 1ps;
  import hoc_pkg::*;

  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Write decodes and the switch group
  wire logic wrSw = clkEn && regWrite && regAddr == HOC_SWITCH_CTRL_ADDR;
  wire logic wrOvr = clkEn && regWrite && regAddr == HOC_OVERRIDE_CTRL_ADDR;
  wire logic [2:0] sw = {prechargeSwitch, chargeSwitch, dischargeSwitch};

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_shutdown_write: assert property (wrSw && regWrData[3] |=> packShutdownOutput)
    else $error("shutdown output not raised by write");
  a_auto_shutdown: assert property (clkEn && ovloShutdownEnable && cellOvervoltageLockout
    |=> packShutdownOutput)
    else $error("automatic shutdown not shown");
  a_short_off: assert property (clkEn && dischargeShortCircuit |=> sw == 3'h0)
    else $error("switches on after short circuit");
  a_hard_off: assert property (clkEn && (internalOvertemp || sleepActive) |=> sw == 3'h0)
    else $error("switches on after hard fault");
  a_scan_pulse: assert property (clkEn && openWireScanStart |=> !openWireScanStart)
    else $error("open wire start pulse longer than one cycle");
  a_ow_ignored: assert property (wrOvr && regWrData[1] && !regWrData[2]
    && !openWireAutoDisable && autoScanEnable && !openWireScanStart |=> !openWireScanStart)
    else $error("open wire scan started while not allowed");
  a_watchdog_scan: assert property (clkEn && watchdogExpired && !i2cTransaction
    |=> !autoScanEnable)
    else $error("scans not stopped after watchdog");
  a_single_pulse: assert property (clkEn && chargerRecoveryPulse
    |-> chargerMonitorOn ##1 !chargerRecoveryPulse)
    else $error("recovery pulse malformed");
  a_balance_sel: assert property (clkEn |=> (hostBalanceDrive & ~$past(balanceSwitchSelect)) == '0)
    else $error("unselected balance output driven");
  a_override_bits: assert property (wrOvr |=> {autoBalanceEnable, autoLoadWatchEnable,
    autoChargerWatchEnable} == ~$past(regWrData[5:3]))
    else $error("automatic enables do not follow overrides");

  // Main scenarios reached
  c_ow_start: cover property (openWireScanStart);
  c_probe: cover property (chargerRecoveryPulse);
  c_watchdog: cover property (watchdogExpired && !autoScanEnable);
endmodule // hoc_regs_checker

bind hoc_override_regs hoc_regs_checker #(.CELLS(CELLS)) hoc_regs_checker_inst (.*);

//--- test/hoc_host_model.sv
// Host microcontroller model issuing single byte register accesses.
// Assumes the one-cycle strobe port timing; drives at falling edges.
module hoc_host_model
(
  input wire logic sys_clk,
  output logic [7:0] regAddr,
  output logic regWrite,
  output logic [7:0] regWrData,
  output logic regRead,
  output logic i2cTransaction,
  input wire logic [7:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  import hoc_pkg::*;

  // Idle bus at start
  initial
  begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regWrData = 8'h00;
    regRead = 1'b0;
    i2cTransaction = 1'b0;
  end

  // One access; released lines show the inverse so stale values are not trusted
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w,
                        output logic [7:0] q);
    @(negedge sys_clk);
    regAddr = a;
    regWrData = (a == HOC_OVERRIDE_CTRL_ADDR) ? {1'b0, d[6:0]} : d;
    regWrite = w;
    regRead = !w;
    i2cTransaction = 1'b1;
    @(negedge sys_clk);
    regWrite = 1'b0;
    regRead = 1'b0;
    i2cTransaction = 1'b0;
    regAddr = ~a;
    regWrData = ~regWrData;
    repeat (2) @(negedge sys_clk);
    q = regRdData;
  endtask
endmodule // hoc_host_model

//--- test/tb.sv
// Self-checking bench for the host override register bank.
// Assumes the host model drives the register port; other inputs driven here.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hoc_pkg::*;

  localparam int SETTLE = 4;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clkEn = 1'b1;
  logic watchdogExpired = 1'b0;
  logic openWireAutoDisable = 1'b0;
  logic openWireScanDone = 1'b0;
  logic chargerSensePin = 1'b0;
  logic autoChargerPresent = 1'b0;
  logic [8:0] flt = 9'h000;
  logic [2:0] sdEn = 3'h0;
  logic [1:0] sdEv = 2'h0;
  logic [7:0] balanceSwitchSelect = 8'h00;
  logic [7:0] pulses = 8'h00;
  wire logic [7:0] regAddr, regWrData, regRdData, hostBalanceDrive;
  wire logic regWrite, regRead, i2cTransaction;
  wire logic chargerPresentFlag, chargerMonitorOn, chargerRecoveryPulse, openWireScanStart;
  wire logic [3:0] outs;
  wire logic [3:0] autos;
  int badCount = 0;
  int totalChecks = 0;

  always #2 sys_clk = ~sys_clk;

  hoc_host_model hoc_host_model_inst (.sys_clk(sys_clk), .regAddr(regAddr),
    .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead),
    .i2cTransaction(i2cTransaction), .regRdData(regRdData));

  hoc_override_regs #(.PROBE_SETTLE_CYC(SETTLE), .CELLS(8)) hoc_override_regs_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr),
    .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
    .i2cTransaction(i2cTransaction), .watchdogExpired(watchdogExpired),
    .chargeOvercurrent(flt[0]), .dischargeOvercurrent(flt[1]),
    .dischargeShortCircuit(flt[2]), .internalOvertemp(flt[3]), .openWireFault(flt[4]),
    .cellOvervoltageLockout(flt[5]), .cellUndervoltageLockout(flt[6]),
    .sleepActive(flt[7]), .switchesOffInput(flt[8]), .cellFailEvent(sdEv[0]),
    .openWireEvent(sdEv[1]), .cellFailShutdownEnable(sdEn[0]),
    .openWireShutdownEnable(sdEn[1]), .ovloShutdownEnable(sdEn[2]),
    .openWireAutoDisable(openWireAutoDisable), .openWireScanDone(openWireScanDone),
    .balanceSwitchSelect(balanceSwitchSelect), .chargerSensePin(chargerSensePin),
    .autoChargerPresent(autoChargerPresent), .chargerPresentFlag(chargerPresentFlag),
    .chargerMonitorOn(chargerMonitorOn), .chargerRecoveryPulse(chargerRecoveryPulse),
    .packShutdownOutput(outs[3]), .prechargeSwitch(outs[2]), .chargeSwitch(outs[1]),
    .dischargeSwitch(outs[0]), .openWireScanStart(openWireScanStart),
    .hostBalanceDrive(hostBalanceDrive), .autoBalanceEnable(autos[3]),
    .autoLoadWatchEnable(autos[2]), .autoChargerWatchEnable(autos[1]),
    .autoScanEnable(autos[0]));

  // Counts recovery and open-wire start pulses
  always @(posedge sys_clk)
    if (chargerRecoveryPulse === 1'b1 || openWireScanStart === 1'b1)
      pulses <= pulses + 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    totalChecks++;
    if (g !== e)
    begin
      badCount++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    hoc_host_model_inst.access(a, d, 1'b1, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    hoc_host_model_inst.access(a, 8'h00, 1'b0, q);
  endtask

  // Switches left on after fault k, all three on before it
  function automatic logic [2:0] exp_sw(input int k, input logic ovr);
    if (k >= 2)
      return 3'h0;
    if (ovr)
      return 3'h7;
    return (k == 0) ? 3'h1 : 3'h2;
  endfunction

  task automatic wrapUp();
    $display("Checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard, far beyond the expected run length
  initial
  begin
    repeat (8000) @(posedge sys_clk);
    badCount++;
    wrapUp();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [7:0] q;
    logic [7:0] d;
    logic [7:0] p0;
    void'($urandom(32'hDB39));
    repeat (8) @(negedge sys_clk);
    sys_rst = 1'b0;
    rd(8'h86, q);
    chk("ctrl1 reset", 8'h00, q);
    rd(8'h87, q);
    chk("ctrl2 reset", 8'h0F, {q[7:4] | q[3:0], autos});
    rd(8'h55, q);
    chk("unmapped read", 8'h00, q);
    // Random override and switch images
    repeat (16)
    begin
      d = 8'($urandom) & 8'h7D;
      wr(8'h87, d);
      rd(8'h87, q);
      chk("ctrl2 read", d, q);
      chk("auto enables", {4'h0, ~d[5:2]}, {4'h0, autos});
      d = 8'($urandom) & 8'hCF;
      wr(8'h86, d);
      rd(8'h86, q);
      chk("ctrl1 read", {4'h0, d[3:0]}, q);
      chk("switch pins", {4'h0, d[3:0]}, {4'h0, outs});
    end
    // Every fault, with and without host switch control
    for (int k = 0; k < 9; k++)
      for (int o = 0; o < 2; o++)
      begin
        wr(8'h87, o[0] ? 8'h40 : 8'h00);
        wr(8'h86, 8'h07);
        flt = 9'h001 << k;
        repeat (4) @(negedge sys_clk);
        flt = 9'h000;
        repeat (4) @(negedge sys_clk);
        chk("switches after fault", {5'h00, exp_sw(k, o[0])}, {5'h00, outs[2:0]});
      end
    // Automatic shutdown sources, enabled then disabled
    for (int k = 0; k < 6; k++)
    begin
      wr(8'h86, 8'h00);
      sdEn = (k < 3) ? 3'h7 : 3'h0;
      {flt[5], sdEv} = 3'h1 << (k % 3);
      @(negedge sys_clk);
      {flt[5], sdEv} = 3'h0;
      sdEn = 3'h0;
      rd(8'h86, q);
      chk("shutdown bit and pin", {6'h00, {2{k < 3}}}, {6'h00, q[3], outs[3]});
    end
    wr(8'h86, 8'h00);
    // Charger probe and fault clear
    autoChargerPresent = 1'b1;
    wr(8'h86, 8'h30);
    chk("probe ignored", 8'h01, {6'h00, chargerMonitorOn, chargerPresentFlag});
    wr(8'h87, 8'h08);
    chargerSensePin = 1'b1;
    p0 = pulses;
    wr(8'h86, 8'h10);
    repeat (SETTLE + 10) @(negedge sys_clk);
    rd(8'h86, q);
    chk("probe bit", 8'h00, q & 8'h30);
    chk("probe flag", 8'h01, {7'h00, chargerPresentFlag});
    chk("recovery pulses", 8'h01, pulses - p0);
    wr(8'h86, 8'h20);
    chk("flag cleared", 8'h00, {7'h00, chargerPresentFlag});
    // Open wire scan: refused, by auto disable, by scan override
    for (int m = 0; m < 3; m++)
    begin
      openWireAutoDisable = (m == 1);
      p0 = pulses;
      wr(8'h87, (m == 2) ? 8'h04 : 8'h00);
      wr(8'h87, (m == 2) ? 8'h06 : 8'h02);
      rd(8'h87, q);
      chk("ow start", {6'h00, {2{m > 0}}}, {6'h00, q[1], pulses - p0 == 8'h01});
      openWireScanDone = 1'b1;
      @(negedge sys_clk);
      openWireScanDone = 1'b0;
      rd(8'h87, q);
      chk("ow done", 8'h00, {6'h00, q[1], openWireScanStart});
    end
    // Host balance drive
    d = 8'($urandom);
    balanceSwitchSelect = d;
    wr(8'h87, 8'h01);
    chk("balance no override", 8'h00, hostBalanceDrive);
    wr(8'h87, 8'h21);
    clkEn = 1'b0;
    wr(8'h87, 8'h00);
    clkEn = 1'b1;
    chk("balance on", d, hostBalanceDrive);
    wr(8'h87, 8'h20);
    chk("balance off", 8'h00, hostBalanceDrive);
    // Watchdog drops scan override and holds automatic scans until the next transaction
    wr(8'h87, 8'h04);
    watchdogExpired = 1'b1;
    @(negedge sys_clk);
    watchdogExpired = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("scan held", 8'h00, {7'h00, autos[0]});
    rd(8'h87, q);
    chk("scan resumed", 8'h01, {6'h00, q[2], autos[0]});
    wrapUp();
  end
endmodule // tb
